// *** core/bmam_core.v ***
// Program and data address map of a small banked controller.
// The core serves fetch and data requests on sys_clk; reads return one cycle later.
// Operation
// - Thirteen-bit program counter forms every program address.
// - Program memory of 14-bit words, 2K, 4K or 8K from zero.
// - Fetch beyond implemented size wraps inside the implemented 2K, 4K or 8K words.
// - After reset fetch starts at program address zero.
// - Interrupt redirects fetch to program address four.
// - Data memory split into four banks with special and general areas.
// - Lowest thirty-two locations of each bank are special registers.
// - Upper ninety-six locations are general RAM, size per variant.
// - Top sixteen locations of banks one to three mirror bank zero.
// - Unimplemented data locations read as zero.
// - Two bank-select bits of the flag register choose the bank for direct access.
// - General RAM of 128, 256 or 336 bytes per variant; the 368-byte setting yields 336.
// - Each register other than the indirect window readable directly or through the pointer register; the program counter low byte is written only directly.
// - Special registers other than the program counter low byte are plain cells holding written value.
`timescale 1ns/100ps
`include "bmam_defs.vh"
module bmam_core
#(
   parameter [1:0] PROG_SIZE = `BMAM_PROG_8K,
   parameter [8:0] GPR_TOP = `BMAM_GPR_TOP_368
)
(
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Program fetch
   input wire fetch_step,
   input wire int_take,
   input wire pc_load,
   input wire [12:0] pc_load_val,
   output reg [12:0] prog_addr_ff,
   // Data access
   input wire data_req,
   input wire data_we,
   input wire data_indirect,
   input wire [6:0] data_dir_addr,
   input wire [7:0] data_wr,
   output reg [7:0] data_rd_ff,
   output reg data_rd_valid_ff,
   // Core register view
   output reg [7:0] flags_ff,
   output reg [7:0] pointer_ff,
   output reg [7:0] program_counter_high_latch_ff
);
   reg [12:0] nxt_pc;
   reg [12:0] pc_mask;
   reg [8:0] full_addr;
   reg [8:0] phys_addr;
   reg [1:0] area_kind;
   reg [7:0] reg_rd;
   reg [1:0] rd_kind_ff;
   reg [7:0] reg_rd_ff;
   reg [7:0] nxt_flags;
   reg [7:0] nxt_pointer;
   reg [7:0] nxt_program_counter_high_latch;
   reg [7:0] nxt_pcl_write;
   reg pcl_we;
   wire [7:0] ram_rd;
   wire ram_we;

   localparam [1:0] KIND_NONE = 2'h0;
   localparam [1:0] KIND_CORE = 2'h1;
   localparam [1:0] KIND_RAM = 2'h2;

   // Size of the implemented program space
   always @*
   begin
      case (PROG_SIZE)
         `BMAM_PROG_2K: pc_mask = `BMAM_MASK_2K;
         `BMAM_PROG_4K: pc_mask = `BMAM_MASK_4K;
         default: pc_mask = `BMAM_MASK_8K;
      endcase
   end

   // Next fetch address; interrupt beats a load, a load beats a step
   always @*
   begin
      pcl_we = data_req && data_we && !data_indirect && data_dir_addr == `BMAM_OFF_PCL;
      nxt_pcl_write = data_wr;
      if (int_take)
         nxt_pc = `BMAM_INT_VEC;
      else if (pc_load)
         nxt_pc = pc_load_val & pc_mask;
      else if (pcl_we)
         nxt_pc = {program_counter_high_latch_ff[4:0], nxt_pcl_write} & pc_mask;
      else if (fetch_step)
         nxt_pc = (prog_addr_ff + 13'h0001) & pc_mask;
      else
         nxt_pc = prog_addr_ff;
   end

   always @(posedge sys_clk)
   begin
      if (rst)
         prog_addr_ff <= `BMAM_RESET_VEC;
      else
         prog_addr_ff <= nxt_pc;
   end

   // Address formation and decode
   always @*
   begin
      if (data_indirect)
         full_addr = {flags_ff[`BMAM_FLAGS_IRP], pointer_ff};
      else
         full_addr = {flags_ff[`BMAM_FLAGS_RP1], flags_ff[`BMAM_FLAGS_RP0],
                      data_dir_addr};
      // Indirect through the indirect window itself reads nothing
      if (data_indirect && full_addr[6:0] == `BMAM_OFF_INDIRECT)
      begin
         area_kind = KIND_NONE;
         phys_addr = 9'h000;
      end
      else if (full_addr[6:0] == `BMAM_OFF_PCL || full_addr[6:0] == `BMAM_OFF_FLAGS ||
               full_addr[6:0] == `BMAM_OFF_POINTER || full_addr[6:0] == `BMAM_OFF_PROGRAM_COUNTER_HIGH_LATCH)
      begin
         area_kind = KIND_CORE;
         phys_addr = {2'b00, full_addr[6:0]};
      end
      else if (full_addr[6:0] == `BMAM_OFF_INTCTL)
      begin
         area_kind = KIND_RAM;
         phys_addr = {2'b00, full_addr[6:0]};
      end
      else if (full_addr[6:0] <= `BMAM_SFR_TOP)
      begin
         area_kind = KIND_RAM;
         // Bank pairs share timer/port B and option/direction cells
         if ((full_addr[6:0] == `BMAM_OFF_TIMER0 || full_addr[6:0] == `BMAM_OFF_PORT_B_DATA))
            phys_addr = {1'b0, full_addr[7], full_addr[6:0]};
         else
            phys_addr = full_addr;
      end
      else if (full_addr[6:0] >= `BMAM_COMMON_LO)
      begin
         area_kind = KIND_RAM;
         phys_addr = {2'b00, full_addr[6:0]};
      end
      else
      begin
         // General RAM packed per bank: bank n holds 80 bytes from 0x20
         phys_addr = full_addr;
         if (({2'b00, full_addr[6:0]} - 9'h020 + {1'b0, full_addr[8:7], 6'h00}
              + {3'b000, full_addr[8:7], 4'h0} + 9'h010) < GPR_TOP)
            area_kind = KIND_RAM;
         else
            area_kind = KIND_NONE;
      end
   end

   assign ram_we = data_req && data_we && area_kind == KIND_RAM;

   bmam_store u_store
   (
      .sys_clk(sys_clk),
      .addr(phys_addr),
      .wr_en(ram_we),
      .wr_data(data_wr),
      .rd_data(ram_rd)
   );

   // Core register reads
   always @*
   begin
      case (full_addr[6:0])
         `BMAM_OFF_PCL: reg_rd = prog_addr_ff[7:0];
         `BMAM_OFF_FLAGS: reg_rd = flags_ff;
         `BMAM_OFF_POINTER: reg_rd = pointer_ff;
         `BMAM_OFF_PROGRAM_COUNTER_HIGH_LATCH: reg_rd = program_counter_high_latch_ff;
         default: reg_rd = 8'h00;
      endcase
   end

   // Core register writes; reserved bank bits are left to software
   always @*
   begin
      nxt_flags = flags_ff;
      nxt_pointer = pointer_ff;
      nxt_program_counter_high_latch = program_counter_high_latch_ff;
      if (data_req && data_we && area_kind == KIND_CORE)
      begin
         case (full_addr[6:0])
            `BMAM_OFF_FLAGS: nxt_flags = data_wr;
            `BMAM_OFF_POINTER: nxt_pointer = data_wr;
            `BMAM_OFF_PROGRAM_COUNTER_HIGH_LATCH: nxt_program_counter_high_latch = data_wr;
            default: nxt_flags = flags_ff;
         endcase
      end
   end

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         flags_ff <= `BMAM_FLAGS_RST;
         pointer_ff <= 8'h00;
         program_counter_high_latch_ff <= 8'h00;
         rd_kind_ff <= KIND_NONE;
         reg_rd_ff <= 8'h00;
         data_rd_valid_ff <= 1'b0;
      end
      else
      begin
         flags_ff <= nxt_flags;
         pointer_ff <= nxt_pointer;
         program_counter_high_latch_ff <= nxt_program_counter_high_latch;
         rd_kind_ff <= (data_req && !data_we) ? area_kind : KIND_NONE;
         reg_rd_ff <= reg_rd;
         data_rd_valid_ff <= data_req && !data_we;
      end
   end

   // Read data comes in the same cycle as the valid strobe by aligning it to the array
   always @*
   begin
      case (rd_kind_ff)
         KIND_RAM: data_rd_ff = ram_rd;
         KIND_CORE: data_rd_ff = reg_rd_ff;
         default: data_rd_ff = 8'h00;
      endcase
   end
endmodule // bmam_core

// *** core/bmam_defs.vh ***
// Constants of the banked memory address map.
// Included by the address map core and its storage module.
`ifndef BMAM_DEFS_VH
`define BMAM_DEFS_VH
`define BMAM_PC_W 13
`define BMAM_PROG_W 14
`define BMAM_RESET_VEC 13'h0000
`define BMAM_INT_VEC 13'h0004
`define BMAM_PROG_2K 2'd0
`define BMAM_PROG_4K 2'd1
`define BMAM_PROG_8K 2'd2
`define BMAM_MASK_2K 13'h07ff
`define BMAM_MASK_4K 13'h0fff
`define BMAM_MASK_8K 13'h1fff
`define BMAM_SFR_TOP 7'h1f
`define BMAM_COMMON_LO 7'h70
`define BMAM_OFF_INDIRECT 7'h00
`define BMAM_OFF_TIMER0 7'h01
`define BMAM_OFF_PCL 7'h02
`define BMAM_OFF_FLAGS 7'h03
`define BMAM_OFF_POINTER 7'h04
`define BMAM_OFF_PORT_B_DATA 7'h06
`define BMAM_OFF_PROGRAM_COUNTER_HIGH_LATCH 7'h0a
`define BMAM_OFF_INTCTL 7'h0b
`define BMAM_FLAGS_RP0 5
`define BMAM_FLAGS_RP1 6
`define BMAM_FLAGS_IRP 7
`define BMAM_FLAGS_RST 8'h18
`define BMAM_GPR_TOP_128 9'h080
`define BMAM_GPR_TOP_256 9'h100
`define BMAM_GPR_TOP_368 9'h170
`define BMAM_RAM_DEPTH 512
`endif

// *** core/bmam_store.v ***
// Byte storage array behind the data address map.
// Written and read on the core clock; read data is registered.
`timescale 1ns/100ps
`include "bmam_defs.vh"
module bmam_store
(
   // Clock; no reset
   input wire sys_clk,
   // Access
   input wire [8:0] addr,
   input wire wr_en,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:`BMAM_RAM_DEPTH-1];

   // Plain cells holding whatever was written
   always @(posedge sys_clk)
   begin
      if (wr_en)
         mem[addr] <= wr_data;
      rd_data <= mem[addr];
   end
endmodule // bmam_store

// *** tb/bmam_core_properties.sv ***
// Assertions on the address map core ports.
// Bound into bmam_core; one clock, sync reset.
`timescale 1ns/100ps
module bmam_core_properties
#(parameter [1:0] PROG_SIZE = 2'h2)
(
   input wire logic sys_clk, rst, fetch_step, int_take, pc_load,
   input wire logic [12:0] prog_addr_ff,
   input wire logic data_req, data_we, data_indirect, data_rd_valid_ff,
   input wire logic [6:0] data_dir_addr,
   input wire logic [7:0] data_wr, flags_ff, pointer_ff, program_counter_high_latch_ff
);
   localparam [12:0] MASK = {PROG_SIZE[1], PROG_SIZE != 2'h0, 11'h7ff};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence dir_wr(a);
      data_req && data_we && !data_indirect && data_dir_addr == a;
   endsequence
   reset_vec_a: assert property ($fell(rst) |->
      prog_addr_ff == 13'h0000) else $error("pc not zero");
   pc_step_a: assert property (fetch_step && !int_take && !pc_load && !data_req |=>
      prog_addr_ff == (($past(prog_addr_ff) + 13'h0001) & MASK)) else $error("bad step");
   int_vec_a: assert property (int_take |=>
      prog_addr_ff == 13'h0004) else $error("pc not four");
   read_answer_a: assert property (data_req && !data_we |=>
      data_rd_valid_ff) else $error("no valid");
   valid_cause_a: assert property (data_rd_valid_ff |->
      $past(data_req) && !$past(data_we)) else $error("stray valid");
   bank_bits_a: assert property (dir_wr(7'h03) |=>
      flags_ff[6:5] == $past(data_wr[6:5])) else $error("bank bits");
   ptr_write_a: assert property (dir_wr(7'h04) |=>
      pointer_ff == $past(data_wr)) else $error("pointer");
   latch_write_a: assert property (dir_wr(7'h0a) |=>
      program_counter_high_latch_ff == $past(data_wr)) else $error("latch");
endmodule // bmam_core_properties
bind bmam_core bmam_core_properties #(.PROG_SIZE(PROG_SIZE)) bmam_core_properties_inst (
   .sys_clk, .rst, .fetch_step, .int_take, .pc_load, .prog_addr_ff, .data_req, .data_we,
   .data_indirect, .data_rd_valid_ff, .data_dir_addr, .data_wr, .flags_ff, .pointer_ff,
   .program_counter_high_latch_ff);

// *** tb/bmam_cpu_model.sv ***
// CPU model: fetch control and data accesses.
// Drives 1 ns after a rising edge, holds one cycle.
`timescale 1ns/100ps
module bmam_cpu_model
(
   input wire logic sys_clk,
   output logic fetch_step, int_take, pc_load, data_req, data_we, data_indirect,
   output logic [12:0] pc_load_val,
   output logic [6:0] data_dir_addr,
   output logic [7:0] data_wr,
   input wire logic [7:0] data_rd_ff,
   input wire logic data_rd_valid_ff
);
   initial
      {fetch_step, int_take, pc_load, data_req, data_we, data_indirect, pc_load_val,
         data_dir_addr, data_wr} = 34'h0;
   task ctl(input logic [2:0] c, input logic [12:0] v);
      @(posedge sys_clk) #1;
      {fetch_step, int_take, pc_load, pc_load_val} = {c, v};
      @(posedge sys_clk) #1;
      {fetch_step, int_take, pc_load} = 3'h0;
   endtask
   task acc(input logic [1:0] wi, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge sys_clk) #1;
      {data_req, data_we, data_indirect, data_dir_addr, data_wr} = {1'h1, wi, a, d};
      @(posedge sys_clk) #1;
      data_req = 1'h0;
      // Stale data toggles so it never passes for a live value
      data_wr = ~d;
      q = data_rd_valid_ff === 1'h1 ? data_rd_ff : 8'hxx;
   endtask
endmodule // bmam_cpu_model

// *** tb/bmam_core_tb.sv ***
// Bench of the address map core, 8K program, 128-byte RAM.
// Stimulus through the CPU model.
`timescale 1ns/100ps
`include "bmam_defs.vh"
module bmam_core_tb;
   logic sys_clk, rst, fetch_step, int_take, pc_load, data_req, data_we, data_indirect;
   logic data_rd_valid_ff;
   logic [12:0] pc_load_val, prog_addr_ff;
   logic [6:0] data_dir_addr;
   logic [7:0] data_wr, data_rd_ff, flags_ff, pointer_ff, program_counter_high_latch_ff, q;
   int fail_count = 0;
   int n_tests = 0;
   bmam_core #(.PROG_SIZE(`BMAM_PROG_8K), .GPR_TOP(`BMAM_GPR_TOP_128)) bmam_core_inst (
      .sys_clk, .rst, .fetch_step, .int_take, .pc_load, .pc_load_val, .prog_addr_ff,
      .data_req, .data_we, .data_indirect, .data_dir_addr, .data_wr, .data_rd_ff,
      .data_rd_valid_ff, .flags_ff, .pointer_ff, .program_counter_high_latch_ff);
   bmam_cpu_model bmam_cpu_model_inst (.sys_clk, .fetch_step, .int_take, .pc_load,
      .data_req, .data_we, .data_indirect, .pc_load_val, .data_dir_addr, .data_wr,
      .data_rd_ff, .data_rd_valid_ff);
   task chk(input logic [12:0] got, exp);
      n_tests++;
      if (got !== exp)
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      fail_count += int'(got !== exp);
   endtask
   task acc(input logic [1:0] wi, input logic [6:0] a, input logic [7:0] d);
      bmam_cpu_model_inst.acc(wi, a, d, q);
   endtask
   task wrap_up;
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task t_fetch;
      chk(prog_addr_ff, 13'h0000);
      bmam_cpu_model_inst.ctl(3'h4, 13'h0000);
      chk(prog_addr_ff, 13'h0001);
      bmam_cpu_model_inst.ctl(3'h1, 13'h1ffe);
      bmam_cpu_model_inst.ctl(3'h4, 13'h0000);
      bmam_cpu_model_inst.ctl(3'h4, 13'h0000);
      chk(prog_addr_ff, 13'h0000);
      bmam_cpu_model_inst.ctl(3'h2, 13'h0000);
      chk(prog_addr_ff, 13'h0004);
      $display("fetch done");
   endtask
   task t_banks;
      for (int b = 0; b < 4; b++)
      begin
         acc(2'h2, 7'h03, {1'h0, b[1:0], 5'h18});
         acc(2'h2, 7'h70, 8'h60 + b[7:0]);
         acc(2'h2, 7'h20, 8'h50 + b[7:0]);
         acc(2'h0, 7'h20, 8'h00);
         chk(q, b < 2 ? 8'h50 + b[7:0] : 8'h00);
         acc(2'h0, 7'h03, 8'h00);
         chk(q[6:5], b[1:0]);
      end
      $display("banks done");
   endtask
   task t_ind;
      acc(2'h2, 7'h04, 8'h20);
      chk(pointer_ff, 8'h20);
      acc(2'h1, 7'h00, 8'h00);
      chk(q, 8'h50);
      acc(2'h2, 7'h04, 8'hf0);
      acc(2'h1, 7'h00, 8'h00);
      chk(q, 8'h63);
      acc(2'h2, 7'h0a, 8'h05);
      acc(2'h2, 7'h02, 8'h34);
      chk(prog_addr_ff, 13'h0534);
      $display("indirect done");
   endtask
   initial
   begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      rst = 1'h1;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'h0;
      t_fetch;
      t_banks;
      t_ind;
      wrap_up;
   end
endmodule // bmam_core_tb
